// [hdl/rss_exec.sv]
// rss_exec: executes rotate right, subtracts, nibble swap and sleep for an 8-bit core
// assumes file data is presented with its address in the same cycle and write-back is done outside
// Operation
// - rotate right changes only carry
// - destination bit picks accumulator or file
// - sleep clears watchdog, sets expiry, clears power-down
// - sleep touches only expiry and power-down flags
// - literal minus accumulator updates carry, half, zero
// - literal subtract writes accumulator, borrow flags
// - file minus accumulator, carry and half borrow
// - borrow subtract uses inverted carry
// - swap exchanges nibbles, no flags
`timescale 1ns/1ps
module rss_exec (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire rss_pkg::rss_op_t            op_sel,
   input  wire logic                        dest_sel,
   input  wire logic [rss_pkg::ADDR_W-1:0]  file_addr,
   input  wire logic [rss_pkg::DATA_W-1:0]  file_rdata,
   input  wire logic [rss_pkg::DATA_W-1:0]  literal_k,
   input  wire logic                        watchdog_tick,
   input  wire logic                        watchdog_clr,
   output logic                             file_we,
   output logic [rss_pkg::ADDR_W-1:0]       file_waddr,
   output logic [rss_pkg::DATA_W-1:0]       file_wdata,
   output logic [rss_pkg::DATA_W-1:0]       acc,
   output logic                             carry_flag,
   output logic                             half_carry_flag,
   output logic                             zero_flag,
   output logic                             watchdog_expiry_flag,
   output logic                             power_down_flag,
   output logic [rss_pkg::WDOG_W-1:0]       watchdog_counter,
   output logic [rss_pkg::PRE_W-1:0]        watchdog_prescaler
);
   // state registers
   logic [rss_pkg::DATA_W-1:0]  acc_ff;
   logic                        carry_ff;
   logic                        half_ff;
   logic                        zero_ff;
   logic                        expiry_ff;
   logic                        pdown_ff;
   logic [rss_pkg::WDOG_W-1:0]  wdog_ff;
   logic [rss_pkg::PRE_W-1:0]   pre_ff;
   logic                        we_ff;
   logic [rss_pkg::ADDR_W-1:0]  waddr_ff;
   logic [rss_pkg::DATA_W-1:0]  wdata_ff;

   // decoded operation strobes
   logic                        is_rotr;
   logic                        is_lsub;
   logic                        is_fsub;
   logic                        is_fsubb;
   logic                        is_swap;
   logic                        is_sleep;
   logic                        is_sub;

   logic [rss_pkg::DATA_W-1:0]  minuend;
   logic [rss_pkg::DATA_W-1:0]  subtrahend_n;
   logic                        borrow_in;
   logic [rss_pkg::DATA_W:0]    sub_cy;
   logic [rss_pkg::DATA_W-1:0]  sub_sum;
   logic                        sub_zero;
   logic [rss_pkg::DATA_W-1:0]  result;
   logic                        has_result;
   logic                        to_file;
   logic                        pre_wrap;

   // illegal code 7 matches none of these and does nothing
   assign is_rotr  = (op_sel == rss_pkg::RSS_OP_ROTR);
   assign is_lsub  = (op_sel == rss_pkg::RSS_OP_LSUB);
   assign is_fsub  = (op_sel == rss_pkg::RSS_OP_FSUB);
   assign is_fsubb = (op_sel == rss_pkg::RSS_OP_FSUBB);
   assign is_swap  = (op_sel == rss_pkg::RSS_OP_SWAP);
   assign is_sleep = (op_sel == rss_pkg::RSS_OP_SLEEP);
   assign is_sub   = is_lsub || is_fsub || is_fsubb;

   // one subtractor shared by all three subtract forms
   always_comb begin
      minuend      = is_lsub ? literal_k : file_rdata;
      subtrahend_n = ~acc_ff;
      borrow_in    = is_fsubb ? ~carry_ff : 1'b0;
   end

   assign sub_cy[0] = ~borrow_in;
   // ripple chain so the nibble carry is a tap, not a second adder
   for (genvar b = 0; b < rss_pkg::DATA_W; b++) begin : g_sub_bit
      assign sub_sum[b]  = minuend[b] ^ subtrahend_n[b] ^ sub_cy[b];
      assign sub_cy[b+1] = (minuend[b] & subtrahend_n[b]) | (sub_cy[b] & (minuend[b] ^ subtrahend_n[b]));
   end
   assign sub_zero = (sub_sum == 8'h00);

   always_comb begin
      has_result = 1'b1;
      result     = sub_sum;
      unique case (op_sel)
         rss_pkg::RSS_OP_NONE: begin
            has_result = 1'b0;
         end
         rss_pkg::RSS_OP_ROTR: begin
            result = {carry_ff, file_rdata[7:1]};
         end
         rss_pkg::RSS_OP_LSUB: begin
            result = sub_sum;
         end
         rss_pkg::RSS_OP_FSUB: begin
            result = sub_sum;
         end
         rss_pkg::RSS_OP_FSUBB: begin
            result = sub_sum;
         end
         rss_pkg::RSS_OP_SWAP: begin
            result = {file_rdata[3:0], file_rdata[7:4]};
         end
         rss_pkg::RSS_OP_SLEEP: begin
            has_result = 1'b0;
         end
         default: begin
            has_result = 1'b0;
         end
      endcase
      to_file = has_result && !is_lsub && (dest_sel == rss_pkg::DEST_FILE);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_ff <= rss_pkg::ACC_RST;
      end else if (has_result && !to_file) begin
         acc_ff <= result;
      end
   end

   // strobe lasts one cycle per file-bound op
   always_ff @(posedge core_clk) begin
      if (rst) begin
         we_ff <= rss_pkg::FLAG_RST;
      end else begin
         we_ff <= to_file;
      end
   end

   // address and data hold the last write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         waddr_ff <= rss_pkg::WADDR_RST;
         wdata_ff <= rss_pkg::WDATA_RST;
      end else if (to_file) begin
         waddr_ff <= file_addr;
         wdata_ff <= result;
      end
   end

   // sleep and swap leave carry alone
   always_ff @(posedge core_clk) begin
      if (rst) begin
         carry_ff <= rss_pkg::FLAG_RST;
      end else if (is_rotr) begin
         carry_ff <= file_rdata[0];
      end else if (is_sub) begin
         carry_ff <= sub_cy[rss_pkg::DATA_W];
      end
   end

   // rotate touches carry only, so half carry waits for a subtract
   always_ff @(posedge core_clk) begin
      if (rst) begin
         half_ff <= rss_pkg::FLAG_RST;
      end else if (is_sub) begin
         half_ff <= sub_cy[rss_pkg::HALF_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         zero_ff <= rss_pkg::FLAG_RST;
      end else if (is_sub) begin
         zero_ff <= sub_zero;
      end
   end

   // expiry only set here; the timeout path lives elsewhere
   always_ff @(posedge core_clk) begin
      if (rst) begin
         expiry_ff <= rss_pkg::EXPIRY_RST;
      end else if (is_sleep) begin
         expiry_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pdown_ff <= rss_pkg::PDOWN_RST;
      end else if (is_sleep) begin
         pdown_ff <= 1'b0;
      end
   end

   assign pre_wrap = (pre_ff == rss_pkg::PRE_LAST);

   // clear beats tick so sleep never keeps a stale count
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pre_ff <= rss_pkg::PRE_CLEAR;
      end else if (is_sleep || watchdog_clr) begin
         pre_ff <= rss_pkg::PRE_CLEAR;
      end else if (watchdog_tick) begin
         pre_ff <= pre_ff + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wdog_ff <= rss_pkg::WDOG_CLEAR;
      end else if (is_sleep || watchdog_clr) begin
         wdog_ff <= rss_pkg::WDOG_CLEAR;
      end else if (watchdog_tick && pre_wrap) begin
         wdog_ff <= wdog_ff + 8'h01;
      end
   end

   assign acc                  = acc_ff;
   assign carry_flag           = carry_ff;
   assign half_carry_flag      = half_ff;
   assign zero_flag            = zero_ff;
   assign watchdog_expiry_flag = expiry_ff;
   assign power_down_flag      = pdown_ff;
   assign watchdog_counter     = wdog_ff;
   assign watchdog_prescaler   = pre_ff;
   assign file_we              = we_ff;
   assign file_waddr           = waddr_ff;
   assign file_wdata           = wdata_ff;
endmodule

// [include/rss_pkg.sv]
// rss_pkg: opcode selects, widths and reset values for the rotate/subtract/swap/sleep unit
// assumes the decoder presents one operation select per instruction cycle
package rss_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int WDOG_W   = 8;
   localparam int PRE_W    = 8;
   localparam int HALF_BIT = 4;

   localparam logic [7:0]        ACC_RST      = 8'h00;
   localparam logic [WDOG_W-1:0] WDOG_CLEAR   = 8'h00;
   localparam logic [PRE_W-1:0]  PRE_CLEAR    = 8'h00;
   localparam logic [PRE_W-1:0]  PRE_LAST     = 8'hFF;
   localparam logic [ADDR_W-1:0] WADDR_RST    = 7'h00;
   localparam logic [7:0]        WDATA_RST    = 8'h00;
   localparam logic              FLAG_RST     = 1'b0;
   localparam logic              EXPIRY_RST   = 1'b1;
   localparam logic              PDOWN_RST    = 1'b1;
   localparam logic              DEST_ACC     = 1'b0;
   localparam logic              DEST_FILE    = 1'b1;

   typedef enum logic [2:0] {
      RSS_OP_NONE   = 3'h0,
      RSS_OP_ROTR   = 3'h1,
      RSS_OP_LSUB   = 3'h2,
      RSS_OP_FSUB   = 3'h3,
      RSS_OP_FSUBB  = 3'h4,
      RSS_OP_SWAP   = 3'h5,
      RSS_OP_SLEEP  = 3'h6
   } rss_op_t;
endpackage

// [dv/rss_exec_props.sv]
// rss_exec_props: port checks bound into rss_exec
// expects one op per edge and a sync reset
`timescale 1ns/1ps
module rss_exec_props (
   input logic             core_clk,
   input logic             rst,
   input rss_pkg::rss_op_t op_sel,
   input logic             dest_sel,
   input logic [6:0]       file_addr,
   input logic [7:0]       file_rdata,
   input logic [7:0]       literal_k,
   input logic             file_we,
   input logic [6:0]       file_waddr,
   input logic [7:0]       file_wdata,
   input logic [7:0]       acc,
   input logic             carry_flag,
   input logic             half_carry_flag,
   input logic             zero_flag,
   input logic             watchdog_expiry_flag,
   input logic             power_down_flag,
   input logic [7:0]       watchdog_counter,
   input logic [7:0]       watchdog_prescaler
);
   // sums taken before the edge, compared after it
   wire [8:0] lsum = {1'b0, literal_k} + {1'b0, ~acc} + 9'h001;
   wire [8:0] fsum = {1'b0, file_rdata} + {1'b0, ~acc} + 9'h001;
   wire [8:0] bsum = {1'b0, file_rdata} + {1'b0, ~acc} + {8'h00, carry_flag};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_rotate_right: assert property (op_sel == 3'h1 && !dest_sel |=> {acc, carry_flag} ==
      {$past(carry_flag), $past(file_rdata)} && $stable(zero_flag)) else $error("rotate");
   a_dest_file: assert property (op_sel inside {3'h1, 3'h3, 3'h4, 3'h5} && dest_sel |=> file_we &&
      file_waddr == $past(file_addr) && $stable(acc)) else $error("destination");
   a_sleep_clear: assert property (op_sel == 3'h6 |=> watchdog_expiry_flag && !power_down_flag &&
      {watchdog_counter, watchdog_prescaler} == 16'h0000) else $error("sleep clear");
   a_sleep_only: assert property (op_sel == 3'h6 |=> !file_we &&
      $stable({acc, carry_flag, half_carry_flag, zero_flag})) else $error("sleep side");
   a_literal_sub: assert property (op_sel == 3'h2 |=> {carry_flag, acc} == $past(lsum)) else $error("lsub");
   a_file_sub: assert property (op_sel == 3'h3 && dest_sel |=> {carry_flag, file_wdata} == $past(fsum))
      else $error("fsub");
   a_borrow_sub: assert property (op_sel == 3'h4 && !dest_sel |=> {carry_flag, acc} == $past(bsum))
      else $error("bsub");
   a_swap_nibbles: assert property (op_sel == 3'h5 && dest_sel |=> $stable({carry_flag, half_carry_flag, zero_flag}) &&
      file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap");
   c_sleep: cover property (op_sel == 3'h6);
   c_borrow_in: cover property (op_sel == 3'h4 && !carry_flag);
   c_rotate_file: cover property (op_sel == 3'h1 && dest_sel);
endmodule
bind rss_exec rss_exec_props u_props (
   .core_clk             (core_clk),
   .rst                  (rst),
   .op_sel               (op_sel),
   .dest_sel             (dest_sel),
   .file_addr            (file_addr),
   .file_rdata           (file_rdata),
   .literal_k            (literal_k),
   .file_we              (file_we),
   .file_waddr           (file_waddr),
   .file_wdata           (file_wdata),
   .acc                  (acc),
   .carry_flag           (carry_flag),
   .half_carry_flag      (half_carry_flag),
   .zero_flag            (zero_flag),
   .watchdog_expiry_flag (watchdog_expiry_flag),
   .power_down_flag      (power_down_flag),
   .watchdog_counter     (watchdog_counter),
   .watchdog_prescaler   (watchdog_prescaler)
);

// [dv/testbench.sv]
// testbench: random and corner ops into rss_exec against a bench model
// drives at the falling edge, samples 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
   logic             core_clk = 1'b0, rst = 1'b1, dest_sel, watchdog_tick, watchdog_clr, file_we, mc, mh, mz;
   logic             carry_flag, half_carry_flag, zero_flag, watchdog_expiry_flag, power_down_flag;
   logic [6:0]       file_addr, file_waddr;
   logic [7:0]       file_rdata, literal_k, file_wdata, acc, watchdog_counter, watchdog_prescaler, ma, mp, mw;
   rss_pkg::rss_op_t op_sel;
   int               miscompares = 0, compares = 0, cyc = 0;
   rss_exec dut (
      .core_clk             (core_clk),
      .rst                  (rst),
      .op_sel               (op_sel),
      .dest_sel             (dest_sel),
      .file_addr            (file_addr),
      .file_rdata           (file_rdata),
      .literal_k            (literal_k),
      .watchdog_tick        (watchdog_tick),
      .watchdog_clr         (watchdog_clr),
      .file_we              (file_we),
      .file_waddr           (file_waddr),
      .file_wdata           (file_wdata),
      .acc                  (acc),
      .carry_flag           (carry_flag),
      .half_carry_flag      (half_carry_flag),
      .zero_flag            (zero_flag),
      .watchdog_expiry_flag (watchdog_expiry_flag),
      .power_down_flag      (power_down_flag),
      .watchdog_counter     (watchdog_counter),
      .watchdog_prescaler   (watchdog_prescaler)
   );
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (++cyc > 2000) test_done();
   // {carry, result, half carry} of x - a with carry-in b
   function automatic logic [9:0] sub(input logic [7:0] x, a, input logic b);
      return {{1'b0, x} + {1'b0, ~a} + {8'h00, b}, {1'b0, x[3:0]} + {1'b0, ~a[3:0]} + {4'h0, b} > 5'h0F};
   endfunction
   task automatic chk(input logic [17:0] g, e);
      compares++;
      if (g !== e) miscompares++;
      if (g !== e) $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
   endtask
   task automatic step(input logic [2:0] o, input logic d, input logic [7:0] f, k);
      logic [9:0] v;
      logic we;
      @(negedge core_clk);
      op_sel = rss_pkg::rss_op_t'(o);
      {dest_sel, file_rdata, literal_k, file_addr, watchdog_tick, watchdog_clr} = {d, f, k, 9'($urandom)};
      // prescaler and counter behave as one 16-bit count
      if (o == 3'h6 || watchdog_clr) {mw, mp} = 16'h0000;
      else if (watchdog_tick) {mw, mp} = {mw, mp} + 16'h0001;
      v = sub(o == 3'h2 ? k : f, ma, o == 3'h4 ? mc : 1'b1);
      if (o == 3'h1) v[8:1] = {mc, f[7:1]};
      if (o == 3'h5) v[8:1] = {f[3:0], f[7:4]};
      we = d && o inside {3'h1, 3'h3, 3'h4, 3'h5};
      if (o inside {3'h2, 3'h3, 3'h4}) {mc, mh, mz} = {v[9], v[0], v[8:1] == 8'h00};
      if (o == 3'h1) mc = f[0];
      if (o inside {[3'h1:3'h5]} && !we) ma = v[8:1];
      @(posedge core_clk);
      #1;
      chk(acc, ma);
      chk({file_we, carry_flag, half_carry_flag, zero_flag}, {we, mc, mh, mz});
      if (we) chk({file_waddr, file_wdata}, {file_addr, v[8:1]});
      chk({watchdog_counter, watchdog_prescaler}, {mw, mp});
      if (o == 3'h6) chk({watchdog_counter, watchdog_prescaler, watchdog_expiry_flag, power_down_flag}, 18'h00002);
   endtask
   initial begin
      op_sel = rss_pkg::RSS_OP_NONE;
      {dest_sel, watchdog_tick, watchdog_clr, file_addr, file_rdata, literal_k} = 26'h0000000;
      void'($urandom(32'h9C15));
      repeat (3) @(posedge core_clk);
      // second pass repeats the run after a mid-run reset
      for (int i = 0; i < 2; i++) begin
         @(negedge core_clk);
         rst = 1'b1;
         op_sel = rss_pkg::RSS_OP_NONE;
         {watchdog_tick, watchdog_clr} = 2'b00;
         @(negedge core_clk);
         rst = 1'b0;
         {ma, mc, mh, mz, mw, mp} = 27'h0000000;
         chk({watchdog_expiry_flag, power_down_flag, acc}, 10'h300);
         chk({carry_flag, half_carry_flag, zero_flag, file_we}, 4'h0);
         chk({watchdog_counter, watchdog_prescaler}, 16'h0000);
         chk({file_waddr, file_wdata}, 15'h0000);
         step(3'h2, 1'b0, 8'h00, 8'h01);
         step(3'h2, 1'b0, 8'h00, 8'h00);
         step(3'h4, 1'b1, 8'h00, 8'h00);
         repeat (300) step(3'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
      end
      test_done();
   end
   task test_done();
      if (cyc > 2000) miscompares++;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
endmodule
